//--- logic/dipc_pkg.sv
// Purpose: Shared constants and types for the output converter control block.
// Assumes: 250 MHz system clock; 8-bit registers on a 32-bit Avalon-MM slave.
// Notes: Register indices are word indices; byte address is four times the index.
package dipc_pkg;
   localparam int CLK_HZ = 250_000_000;
   localparam int TIMEBASE_HZ = 5_000_000;
   localparam int TB_DIV = CLK_HZ / TIMEBASE_HZ;
   localparam int TB_W = $clog2(TB_DIV);
   localparam int PRESCALE_DIV = 10;
   localparam int PS_W = $clog2(PRESCALE_DIV);
   localparam int ADDR_W = 14;
   localparam int LVL_W = 12;

   localparam logic [11:0] IDX_CTRL_B = 12'h405;
   localparam logic [11:0] IDX_CTRL_C = 12'h406;
   localparam logic [11:0] IDX_STATUS = 12'h407;
   localparam logic [7:0] RST_CTRL_B = 8'h00;
   localparam logic [7:0] RST_CTRL_C = 8'h00;
   localparam logic [7:0] RST_STATUS = 8'h30;

   // Control register B fields.
   localparam int B_FIFO_IRQ_MODE = 6;
   localparam int B_IRQ_ENABLE = 5;
   localparam int B_DMA_ENABLE = 2;
   localparam int B_DMA_CH_HI = 1;
   localparam int B_DMA_CH_LO = 0;
   localparam logic [7:0] B_WR_MASK = 8'h67;
   // Control register C fields.
   localparam int C_RANGE_CONV1 = 7;
   localparam int C_RANGE_CONV0 = 6;
   localparam int C_PRESCALER_EN = 3;
   localparam int C_EXT_POLARITY = 2;
   localparam int C_SRC_HI = 1;
   localparam int C_SRC_LO = 0;
   localparam logic [7:0] C_WR_MASK = 8'hCF;
   // Status register fields.
   localparam int S_CONV_ENABLE = 7;
   localparam int S_SOFT_CONVERT = 6;
   localparam int S_FIFO_HALF = 5;
   localparam int S_FIFO_ROOM = 4;
   localparam int S_FIFO_HAS_DATA = 3;
   localparam int S_UNDERFLOW = 2;
   localparam int S_DMA_DONE = 1;
   localparam int S_PENDING = 0;

   localparam logic [LVL_W-1:0] LVL_HALF_ABOVE = 12'h401;
   localparam logic [LVL_W-1:0] LVL_HALF_AT = 12'h400;
   localparam logic [LVL_W-1:0] LVL_FULL = 12'h800;
   localparam logic [LVL_W-1:0] LVL_EMPTY = 12'h000;

   typedef enum logic [1:0] {
      SRC_SOFT = 2'b00,
      SRC_INT_PACER = 2'b01,
      SRC_EXT_PACER = 2'b10,
      SRC_ADC_PACER = 2'b11
   } dipc_pacer_src_type;

   typedef enum logic [1:0] {
      DMA_OFF = 2'b00,
      DMA_CH5 = 2'b01,
      DMA_CH6 = 2'b10,
      DMA_CH7 = 2'b11
   } dipc_dma_ch_type;

   localparam logic [1:0] SEL_CONV0 = 2'b00;
   localparam logic [1:0] SEL_CONV1 = 2'b01;
   localparam logic [1:0] SEL_BOTH = 2'b10;

   typedef struct packed {
      logic conv0;
      logic conv1;
   } dipc_update_type;
endpackage

//--- logic/dipc_top.sv
// Purpose: Interrupt, DMA, range, pacer and status control for a two-channel output path.
// Assumes: FIFO level, underflow, busy and pacer ticks come from logic on ref_clk_in.
// Notes: Pins ext_pacer_in and dma_tc_in are synchronised by three flip-flops.
// Functional notes
// - Mode 0: event on level 1025 to 1024; mode 1: event on leaving full.
// - FIFO interrupt mode matters only with irq_enable set and DMA channel off.
// - Irq enabled, DMA off: interrupt on chosen FIFO event, underflow or terminal count.
// - Irq enabled, DMA on: interrupt on host terminal count.
// - dma_enable gates DMA transfers for output data.
// - Channel field: 00 off, 01 channel 5, 10 channel 6, 11 channel 7.
// - DMA request stays asserted while the FIFO has room for one more value.
// - Gain code bit 0 sets converter 0 range, bit 1 converter 1.
// - Pacer counter clocks at 5 MHz, or 500 kHz with prescaler enabled.
// - External pacer active on rising edge at polarity 0, falling at 1.
// - Source field: 00 software, 01 internal, 10 external, 11 input-side pacer.
// - Status register resets to 30h.
// - No conversions while conversion_enable is 0.
// - Underflow with irq_enable set clears conversion_enable.
// - conversion_enable written only when write bit 5 is 0; half flag is live.
// - Writing 1 to soft_convert with software source updates converters; 0 does nothing.
// - Reading soft_convert shows converters busy.
// - fifo_half_flag is 1 below 1025 words, else 0.
// - Half event with mode 0, irq enabled, DMA off sets pending flag and interrupt.
// - Status write of 0 clears an event flag, 1 preserves it; never sets.
// - Both selected: converter 0 takes first value, converter 1 next, together.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/100ps
module dipc_top (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic [dipc_pkg::ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic [dipc_pkg::LVL_W-1:0] fifo_level_in,
   input wire logic fifo_underflow_in,
   input wire logic [1:0] conv_sel_in,
   input wire logic conv_busy_in,
   input wire logic int_pacer_tick_in,
   input wire logic adc_pacer_tick_in,
   input wire logic ext_pacer_in,
   input wire logic dma_tc_in,
   output logic [2:0] dma_req_out,
   output logic irq_out,
   output logic [1:0] range_sel_out,
   output logic pacer_cnt_tick_out,
   output dipc_pkg::dipc_update_type conv_update_out
);
   import dipc_pkg::*;

   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [11:0] idx);
      reg_hit = (addr[ADDR_W-1:2] == idx);
   endfunction

   function automatic logic [2:0] dma_onehot(input logic [1:0] ch);
      logic [2:0] r;
      r = 3'h0;
      unique case (ch)
         DMA_OFF: r = 3'h0;
         DMA_CH5: r = 3'h1;
         DMA_CH6: r = 3'h2;
         DMA_CH7: r = 3'h4;
      endcase
      dma_onehot = r;
   endfunction

   logic ack_ff;
   logic [31:0] rdata_ff;
   logic [7:0] ctrl_b_ff;
   logic [7:0] ctrl_c_ff;
   logic conversion_enable_ff, uf_ff, tc_flag_ff, pend_ff;
   logic [LVL_W-1:0] lvl_prev_ff;
   logic ext_meta_ff, ext_s2_ff, ext_s3_ff;
   logic tc_meta_ff, tc_s2_ff, tc_s3_ff;
   logic [TB_W-1:0] tb_cnt_ff;
   logic [PS_W-1:0] ps_cnt_ff;
   logic [2:0] dma_req_ff;
   logic tick_ff;
   dipc_update_type upd_ff;

   logic req, wr_acc, st_wr, b_wr, c_wr;
   logic irq_en, dma_off, dma_on, half_evt, room_evt, fifo_evt, tc_evt, set_pend;
   logic ext_edge, tb_tick, ps_wrap, src_tick, soft_go, conv_go, room, conv_busy;
   logic [7:0] status_rd;
   dipc_update_type nxt_upd;

   // Bus slave: one wait cycle, then the access completes.
   assign req = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = req & ~ack_ff;
   assign wr_acc = avs_write_in & ack_ff & avs_byteenable_in[0];
   assign st_wr = wr_acc & reg_hit(avs_address_in, IDX_STATUS);
   assign b_wr = wr_acc & reg_hit(avs_address_in, IDX_CTRL_B);
   assign c_wr = wr_acc & reg_hit(avs_address_in, IDX_CTRL_C);
   assign avs_readdata_out = rdata_ff;

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         rdata_ff <= 32'h0000_0000;
      end else if (avs_read_in & ~ack_ff) begin
         if (reg_hit(avs_address_in, IDX_CTRL_B)) begin
            rdata_ff <= {24'h00_0000, ctrl_b_ff};
         end else if (reg_hit(avs_address_in, IDX_CTRL_C)) begin
            rdata_ff <= {24'h00_0000, ctrl_c_ff};
         end else if (reg_hit(avs_address_in, IDX_STATUS)) begin
            rdata_ff <= {24'h00_0000, status_rd};
         end else begin
            rdata_ff <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         ctrl_b_ff <= RST_CTRL_B;
         ctrl_c_ff <= RST_CTRL_C;
      end else begin
         if (b_wr) begin
            ctrl_b_ff <= avs_writedata_in[7:0] & B_WR_MASK;
         end
         if (c_wr) begin
            ctrl_c_ff <= avs_writedata_in[7:0] & C_WR_MASK;
         end
      end
   end

   assign irq_en = ctrl_b_ff[B_IRQ_ENABLE];
   assign dma_off = ({ctrl_b_ff[B_DMA_CH_HI], ctrl_b_ff[B_DMA_CH_LO]} == DMA_OFF);
   assign dma_on = ctrl_b_ff[B_DMA_ENABLE];
   assign range_sel_out = {ctrl_c_ff[C_RANGE_CONV1], ctrl_c_ff[C_RANGE_CONV0]};

   // Pin synchronisers; only the second and third stages feed logic.
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         ext_meta_ff <= 1'b0;
         ext_s2_ff <= 1'b0;
         ext_s3_ff <= 1'b0;
         tc_meta_ff <= 1'b0;
         tc_s2_ff <= 1'b0;
         tc_s3_ff <= 1'b0;
      end else begin
         ext_meta_ff <= ext_pacer_in;
         ext_s2_ff <= ext_meta_ff;
         ext_s3_ff <= ext_s2_ff;
         tc_meta_ff <= dma_tc_in;
         tc_s2_ff <= tc_meta_ff;
         tc_s3_ff <= tc_s2_ff;
      end
   end

   assign ext_edge = ctrl_c_ff[C_EXT_POLARITY] ? (ext_s3_ff & ~ext_s2_ff)
                                               : (~ext_s3_ff & ext_s2_ff);
   assign tc_evt = tc_s2_ff & ~tc_s3_ff;

   // FIFO level events.
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         lvl_prev_ff <= LVL_EMPTY;
      end else begin
         lvl_prev_ff <= fifo_level_in;
      end
   end

   assign half_evt = (lvl_prev_ff == LVL_HALF_ABOVE) && (fifo_level_in == LVL_HALF_AT);
   assign room_evt = (lvl_prev_ff == LVL_FULL) && (fifo_level_in != LVL_FULL);
   assign fifo_evt = ctrl_b_ff[B_FIFO_IRQ_MODE] ? room_evt : half_evt;
   assign set_pend = irq_en & ((dma_off & (fifo_evt | fifo_underflow_in)) | tc_evt);

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         pend_ff <= RST_STATUS[S_PENDING];
      end else if (set_pend) begin
         pend_ff <= 1'b1;
      end else if (st_wr & ~avs_writedata_in[S_PENDING]) begin
         pend_ff <= 1'b0;
      end
   end
   assign irq_out = pend_ff;

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         uf_ff <= RST_STATUS[S_UNDERFLOW];
      end else if (fifo_underflow_in) begin
         uf_ff <= 1'b1;
      end else if (st_wr & ~avs_writedata_in[S_UNDERFLOW]) begin
         uf_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         tc_flag_ff <= RST_STATUS[S_DMA_DONE];
      end else if (tc_evt & dma_on) begin
         tc_flag_ff <= 1'b1;
      end else if (st_wr & ~avs_writedata_in[S_DMA_DONE]) begin
         tc_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         conversion_enable_ff <= RST_STATUS[S_CONV_ENABLE];
      end else if (fifo_underflow_in & irq_en) begin
         conversion_enable_ff <= 1'b0;
      end else if (st_wr & ~avs_writedata_in[S_FIFO_HALF]) begin
         conversion_enable_ff <= avs_writedata_in[S_CONV_ENABLE];
      end
   end

   assign conv_busy = conv_busy_in | upd_ff.conv0 | upd_ff.conv1;
   always_comb begin
      status_rd = 8'h00;
      status_rd[S_CONV_ENABLE] = conversion_enable_ff;
      status_rd[S_SOFT_CONVERT] = conv_busy;
      status_rd[S_FIFO_HALF] = (fifo_level_in < LVL_HALF_ABOVE);
      status_rd[S_FIFO_ROOM] = (fifo_level_in != LVL_FULL);
      status_rd[S_FIFO_HAS_DATA] = (fifo_level_in != LVL_EMPTY);
      status_rd[S_UNDERFLOW] = uf_ff;
      status_rd[S_DMA_DONE] = tc_flag_ff;
      status_rd[S_PENDING] = pend_ff;
   end

   // DMA request per host channel, demand style.
   assign room = (fifo_level_in != LVL_FULL);
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         dma_req_ff <= 3'h0;
      end else if (dma_on & room) begin
         dma_req_ff <= dma_onehot({ctrl_b_ff[B_DMA_CH_HI], ctrl_b_ff[B_DMA_CH_LO]});
      end else begin
         dma_req_ff <= 3'h0;
      end
   end
   assign dma_req_out = dma_req_ff;

   // Pacer counter timebase: 5 MHz, or 500 kHz through the prescaler.
   assign tb_tick = (tb_cnt_ff == TB_W'(TB_DIV - 1));
   assign ps_wrap = tb_tick & (ps_cnt_ff == PS_W'(PRESCALE_DIV - 1));
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         tb_cnt_ff <= '0;
      end else if (tb_tick) begin
         tb_cnt_ff <= '0;
      end else begin
         tb_cnt_ff <= tb_cnt_ff + TB_W'(1);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         ps_cnt_ff <= '0;
      end else if (ps_wrap) begin
         ps_cnt_ff <= '0;
      end else if (tb_tick) begin
         ps_cnt_ff <= ps_cnt_ff + PS_W'(1);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= ctrl_c_ff[C_PRESCALER_EN] ? ps_wrap : tb_tick;
      end
   end
   assign pacer_cnt_tick_out = tick_ff;

   // Conversion source and converter update strobes.
   assign soft_go = st_wr & avs_writedata_in[S_SOFT_CONVERT];
   always_comb begin
      src_tick = 1'b0;
      unique case (dipc_pacer_src_type'({ctrl_c_ff[C_SRC_HI], ctrl_c_ff[C_SRC_LO]}))
         SRC_SOFT: src_tick = soft_go;
         SRC_INT_PACER: src_tick = int_pacer_tick_in;
         SRC_EXT_PACER: src_tick = ext_edge;
         SRC_ADC_PACER: src_tick = adc_pacer_tick_in;
      endcase
   end
   assign conv_go = conversion_enable_ff & src_tick;

   always_comb begin
      nxt_upd.conv0 = conv_go & ((conv_sel_in == SEL_CONV0) | (conv_sel_in == SEL_BOTH));
      nxt_upd.conv1 = conv_go & ((conv_sel_in == SEL_CONV1) | (conv_sel_in == SEL_BOTH));
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         upd_ff <= '0;
      end else begin
         upd_ff <= nxt_upd;
      end
   end
   assign conv_update_out = upd_ff;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);

   a_half_event: assert property (irq_en && dma_off && !ctrl_b_ff[B_FIFO_IRQ_MODE] &&
      $past(fifo_level_in) == LVL_HALF_ABOVE && fifo_level_in == LVL_HALF_AT |=> irq_out)
      else $error("half-full event did not raise interrupt");
   a_room_event: assert property (irq_en && dma_off && ctrl_b_ff[B_FIFO_IRQ_MODE] &&
      $past(fifo_level_in) == LVL_FULL && fifo_level_in != LVL_FULL |=> irq_out)
      else $error("not-full event did not raise interrupt");
   a_mode_ignored: assert property (!irq_out && !dma_off && !tc_evt |=> !irq_out)
      else $error("interrupt raised with DMA on and no terminal count");
   a_underflow_irq: assert property (irq_en && dma_off && fifo_underflow_in |=> irq_out && uf_ff)
      else $error("underflow did not raise interrupt");
   a_tc_irq: assert property (irq_en && tc_s2_ff && !tc_s3_ff |=> irq_out)
      else $error("terminal count did not raise interrupt");
   a_dma_gate: assert property (!dma_on |=> dma_req_out == 3'h0)
      else $error("DMA request while DMA disabled");
   a_dma_room: assert property (dma_on && room && ctrl_b_ff[1:0] == DMA_CH6 |=>
      dma_req_out == 3'h2)
      else $error("DMA request missing on channel 6");
   a_dma_full: assert property (fifo_level_in == LVL_FULL |=> dma_req_out == 3'h0)
      else $error("DMA request while FIFO full");
   a_tick_gap: assert property (tick_ff |=> !tick_ff [*8])
      else $error("pacer ticks too close");
   a_uf_stop: assert property (irq_en && fifo_underflow_in |=> !conversion_enable_ff)
      else $error("underflow did not stop conversions");
   a_no_conv: assert property (!conversion_enable_ff |=> conv_update_out == '0)
      else $error("conversion while disabled");
   a_conversion_enable_masked: assert property (st_wr && avs_writedata_in[S_FIFO_HALF] &&
      !fifo_underflow_in |=> conversion_enable_ff == $past(conversion_enable_ff))
      else $error("conversion enable changed with bit 5 set");
   a_soft_both: assert property (st_wr && avs_writedata_in[S_SOFT_CONVERT] && conversion_enable_ff &&
      ctrl_c_ff[1:0] == SRC_SOFT && conv_sel_in == SEL_BOTH |=> conv_update_out == 2'b11)
      else $error("software conversion did not update both converters");
   a_irq_hold: assert property (irq_out && !(st_wr && !avs_writedata_in[S_PENDING]) |=> irq_out)
      else $error("interrupt dropped without software clear");
   a_bus_answer: assert property (req && !ack_ff |=> !avs_waitrequest_out)
      else $error("bus answer late");
   a_dma_ch5: assert property (dma_on && room && ctrl_b_ff[1:0] == DMA_CH5 |=>
      dma_req_out == 3'h1)
      else $error("DMA request missing on channel 5");
   a_range_follow: assert property (c_wr |=>
      range_sel_out == $past({avs_writedata_in[C_RANGE_CONV1], avs_writedata_in[C_RANGE_CONV0]}))
      else $error("range select does not follow register write");
   a_ext_update: assert property (conversion_enable_ff && ctrl_c_ff[1:0] == SRC_EXT_PACER &&
      ext_edge && conv_sel_in == SEL_CONV0 |=> conv_update_out.conv0)
      else $error("external pacer edge did not update converter 0");
   a_soft_ignored: assert property (st_wr && !avs_writedata_in[S_SOFT_CONVERT] &&
      ctrl_c_ff[1:0] == SRC_SOFT |=> conv_update_out == '0)
      else $error("software conversion ran without a request");
   a_busy_read: assert property (avs_read_in && !ack_ff && conv_busy_in &&
      reg_hit(avs_address_in, IDX_STATUS) |=> avs_readdata_out[S_SOFT_CONVERT])
      else $error("busy converters not shown on read");
   a_half_read: assert property (avs_read_in && !ack_ff &&
      fifo_level_in == LVL_HALF_ABOVE && reg_hit(avs_address_in, IDX_STATUS) |=>
      !avs_readdata_out[S_FIFO_HALF])
      else $error("half flag set with 1025 words stored");
   a_flag_no_set: assert property (st_wr && !uf_ff && !fifo_underflow_in |=> !uf_ff)
      else $error("status write set the underflow flag");

   // Covers mark the main conversion, event and DMA scenarios.
   c_soft_conv: cover property (soft_go && conversion_enable_ff);
   c_room_irq: cover property (room_evt && set_pend);
   c_half_irq: cover property (half_evt && set_pend);
   c_dma_req: cover property (dma_req_out != 3'h0);
   c_uf_stop: cover property (fifo_underflow_in && irq_en && conversion_enable_ff);
endmodule

//--- verification/dipc_host_model.sv
// Purpose: Host bus DMA controller seen from the output converter block.
// Assumes: Terminal count is a clean active-high level driven at all times.
// Notes: One burst of sixteen demand cycles per enable, then terminal count.
`timescale 1ns/100ps
module dipc_host_model (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic en_in,
   input wire logic [2:0] req_in,
   output logic tc_out
);
   int cnt;
   // A word moves only on a cycle in which the request is held, as in demand transfers.
   always @(posedge clk_in) begin
      if (!rstn_in || !en_in) begin
         cnt <= 0;
         tc_out <= 1'b0;
      end else begin
         if ((req_in != 3'b000 || cnt >= 16) && cnt < 24) begin
            cnt <= cnt + 1;
         end
         tc_out <= (cnt >= 16 && cnt < 20);
      end
   end
endmodule

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the output converter control block.
// Assumes: One 250 MHz clock; register reads are scored from a queue.
// Notes: Random FIFO levels come from a fixed seed.
`timescale 1ns/100ps
module tb_top;
   import dipc_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [13:0] addr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] ben = 4'hF;
   logic [31:0] rdata;
   logic wreq;
   logic [11:0] lvl = 12'h000;
   logic uf = 1'b0;
   logic [1:0] sel = 2'b00;
   logic busy = 1'b0;
   logic itick = 1'b0;
   logic atick = 1'b0;
   logic ext = 1'b0;
   logic tc;
   logic hen = 1'b0;
   logic [2:0] dreq;
   logic irq;
   logic [1:0] rng;
   logic ptick;
   dipc_update_type upd;
   logic [1:0] upd_last;
   logic [7:0] expq[$];
   logic [7:0] evb[6] = '{8'h20, 8'h00, 8'h21, 8'h60, 8'h60, 8'h20};
   logic [11:0] evf[6] = '{12'h401, 12'h401, 12'h401, 12'h401, 12'h800, 12'h800};
   logic eve[6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
   logic [1:0] selx[4] = '{2'b10, 2'b01, 2'b11, 2'b00};
   int mismatches = 0;
   int cmp_count = 0;
   int nupd = 0;
   int nexp;
   int seed = 77103;
   always #2 clk = ~clk;
   dipc_top i_dipc_top (.ref_clk_in(clk), .rstn_in(rstn), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_byteenable_in(ben), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
      .fifo_level_in(lvl), .fifo_underflow_in(uf), .conv_sel_in(sel), .conv_busy_in(busy),
      .int_pacer_tick_in(itick), .adc_pacer_tick_in(atick), .ext_pacer_in(ext),
      .dma_tc_in(tc), .dma_req_out(dreq), .irq_out(irq), .range_sel_out(rng),
      .pacer_cnt_tick_out(ptick), .conv_update_out(upd));
   dipc_host_model i_dipc_host_model (.clk_in(clk), .rstn_in(rstn), .en_in(hen),
      .req_in(dreq), .tc_out(tc));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
      @(posedge clk);
      addr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      if (w) wr <= 1'b1;
      else rd <= 1'b1;
      do @(posedge clk); while (wreq !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic wr_r(input logic [11:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask
   task automatic rd_r(input logic [11:0] idx, input logic [7:0] e);
      expq.push_back(e);
      bus(1'b0, idx, 8'h00);
   endtask
   task automatic meas(input int exp);
      int n;
      n = 0;
      repeat (2) begin
         @(posedge clk);
         while (ptick !== 1'b1) @(posedge clk);
      end
      do begin
         @(posedge clk);
         n++;
      end while (ptick !== 1'b1);
      check("tick_period", n, exp);
   endtask
   task automatic stim(input int k);
      if (k == 0) wr_r(IDX_STATUS, 8'hC7);
      if (k == 1) itick <= 1'b1;
      if (k == 2) ext <= 1'b1;
      if (k == 3) atick <= 1'b1;
      cyc(1);
      itick <= 1'b0;
      atick <= 1'b0;
      cyc(8);
      ext <= 1'b0;
      cyc(8);
   endtask
   always @(posedge clk) begin
      if (rd && wreq === 1'b0 && expq.size() > 0) begin
         check("readdata", rdata, {24'h0, expq.pop_front()});
      end
      if (upd !== 2'b00) begin
         nupd++;
         upd_last = upd;
      end
   end
   initial begin
      repeat (30000) @(posedge clk);
      mismatches++;
      conclude();
   end
   initial begin
      logic [11:0] r;
      cyc(2);
      rstn <= 1'b1;
      rd_r(IDX_CTRL_B, RST_CTRL_B);
      rd_r(IDX_CTRL_C, RST_CTRL_C);
      rd_r(IDX_STATUS, 8'h30);
      rd_r(12'h400, 8'h00);
      wr_r(IDX_CTRL_B, 8'hFF);
      rd_r(IDX_CTRL_B, 8'h67);
      ben <= 4'hE;
      wr_r(IDX_CTRL_B, 8'h00);
      ben <= 4'hF;
      rd_r(IDX_CTRL_B, 8'h67);
      for (int i = 0; i < 4; i++) begin
         wr_r(IDX_CTRL_C, {i[1:0], 6'h0F});
         rd_r(IDX_CTRL_C, {i[1:0], 6'h0F});
         check("range", rng, i[1:0]);
      end
      wr_r(IDX_CTRL_C, 8'h00);
      meas(50);
      wr_r(IDX_CTRL_C, 8'h08);
      meas(500);
      wr_r(IDX_STATUS, 8'h07);
      lvl <= 12'h064;
      for (int i = 0; i < 6; i++) begin
         wr_r(IDX_CTRL_B, evb[i]);
         lvl <= evf[i];
         cyc(4);
         rd_r(IDX_STATUS, (evf[i] == 12'h401) ? 8'h18 : 8'h08);
         lvl <= evf[i] - 12'h001;
         cyc(4);
         check("irq_event", irq, eve[i]);
         wr_r(IDX_STATUS, 8'h26);
         cyc(2);
         check("irq_clear", irq, 1'b0);
         lvl <= 12'h064;
      end
      wr_r(IDX_CTRL_B, 8'h20);
      wr_r(IDX_STATUS, 8'h87);
      rd_r(IDX_STATUS, 8'hB8);
      wr_r(IDX_STATUS, 8'h27);
      rd_r(IDX_STATUS, 8'hB8);
      uf <= 1'b1;
      cyc(1);
      uf <= 1'b0;
      cyc(3);
      check("irq_underflow", irq, 1'b1);
      rd_r(IDX_STATUS, 8'h3D);
      wr_r(IDX_STATUS, 8'h22);
      rd_r(IDX_STATUS, 8'h38);
      check("irq_cleared", irq, 1'b0);
      busy <= 1'b1;
      rd_r(IDX_STATUS, 8'h78);
      busy <= 1'b0;
      wr_r(IDX_CTRL_B, 8'h00);
      wr_r(IDX_STATUS, 8'h87);
      for (int s = 0; s < 4; s++) begin
         wr_r(IDX_CTRL_C, s[7:0]);
         for (int k = 0; k < 4; k++) begin
            nexp = nupd + ((k == s) ? 1 : 0);
            stim(k);
            check("updates", nupd, nexp);
         end
      end
      wr_r(IDX_CTRL_C, 8'h06);
      nexp = nupd;
      ext <= 1'b1;
      cyc(8);
      check("updates_pol", nupd, nexp);
      ext <= 1'b0;
      cyc(8);
      check("updates_pol", nupd, nexp + 1);
      wr_r(IDX_CTRL_C, 8'h00);
      for (int i = 0; i < 4; i++) begin
         sel <= i[1:0];
         upd_last = 2'b00;
         wr_r(IDX_STATUS, 8'hC7);
         cyc(3);
         check("update_sel", upd_last, selx[i]);
      end
      wr_r(IDX_STATUS, 8'h07);
      wr_r(IDX_CTRL_C, 8'h01);
      nexp = nupd;
      stim(1);
      check("updates_off", nupd, nexp);
      for (int c = 0; c < 4; c++) begin
         for (int i = 0; i < 4; i++) begin
            r = (i == 0) ? LVL_FULL : 12'($unsigned($random(seed)) % 2048);
            lvl <= r;
            wr_r(IDX_CTRL_B, {5'h00, (i != 1), c[1:0]});
            cyc(2);
            check("dma_req", dreq, (c == 0 || i == 1 || r == LVL_FULL) ? 0 : 1 << (c - 1));
            rd_r(IDX_STATUS, {2'b00, r < 12'h401, r != LVL_FULL, r != 12'h000, 3'b000});
         end
      end
      lvl <= 12'h064;
      wr_r(IDX_CTRL_B, 8'h25);
      hen <= 1'b1;
      cyc(60);
      check("irq_tc", irq, 1'b1);
      rd_r(IDX_STATUS, 8'h3B);
      hen <= 1'b0;
      wr_r(IDX_STATUS, 8'h20);
      rd_r(IDX_STATUS, 8'h38);
      conclude();
   end
endmodule
